/* File: frt_ctrl.sv */
// free-running timer channel: control/status registers, counter, compare, capture
//
// Notes on behaviour
// - control register, 8 bits, zero on reset/standby
// - bit 7 gates capture interrupt request
// - bit 6 gates compare-B interrupt request
// - bit 5 gates compare-A interrupt request
// - bit 4 gates overflow interrupt request
// - bit 3 lets compare-B match drive pin
// - bit 2 lets compare-A match drive pin
// - clock select: /2, /8, /32, external
// - external source counts each rising pin edge
// - status register, 8 bits, zero on reset/standby
// - flags set by hardware; writing 1 ignored
// - flag clears only after read-as-1 then write-0
// - capture sets bit 7 and loads capture
// - compare-B match sets bit 6
// - compare-A match sets bit 5
// - counter wrap to zero sets bit 4
// - bit 3 is compare-B pin level
// - bit 2 is compare-A pin level
// - bit 1 picks capture edge, 1 rising
// - bit 0 clears counter on compare-A match
// - counter increments once per count pulse
// - capture loads even if flag still set
// - four separate request lines, fixed priority order
`timescale 1ns/1ps
`include "frt_defines.svh"
`default_nettype none
module frt_ctrl (
   // clock, reset, standby
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        standby,
   // cpu register bus
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   input  wire logic [7:0]  bus_wdata,
   output logic      [7:0]  bus_rdata,
   // timer pins
   input  wire logic        capture_in_pin,
   input  wire logic        ext_count_clock_pin,
   output logic             compare_a_out_pin,
   output logic             compare_a_out_oe,
   output logic             compare_b_out_pin,
   output logic             compare_b_out_oe,
   // interrupt requests, highest priority first
   output logic             capture_irq,
   output logic             compare_a_irq,
   output logic             compare_b_irq,
   output logic             overflow_irq
);
   frt_pkg::frt_ctl_s  ctl_r;
   frt_pkg::frt_ctl_s  ctl_nxt;
   frt_pkg::frt_csr_s  csr_r;
   frt_pkg::frt_csr_s  csr_nxt;
   frt_pkg::frt_evt_s  evt;
   logic [3:0]         arm_r;
   logic [3:0]         arm_nxt;
   logic [3:0]         flag_clr;
   logic [15:0]        cnt_r;
   logic [15:0]        cnt_nxt;
   logic [15:0]        cmpa_r;
   logic [15:0]        cmpa_nxt;
   logic [15:0]        cmpb_r;
   logic [15:0]        cmpb_nxt;
   logic [15:0]        capv_r;
   logic [15:0]        capv_nxt;
   logic [7:0]         temp_r;
   logic [7:0]         temp_nxt;
   logic [7:0]         rdata_r;
   logic [7:0]         rdata_nxt;
   logic               pin_a_r;
   logic               pin_a_nxt;
   logic               pin_b_r;
   logic               pin_b_nxt;
   logic [1:0]         pin_rise;
   logic [1:0]         pin_fall;
   logic               inc;
   logic               match_a;
   logic               match_b;
   logic               cnt_clr;
   logic               cap_evt;
   logic               wr_ctl;
   logic               wr_csr;
   logic               rd_csr;
   logic               wr_cnt_l;
   logic               wr_cmpa_l;
   logic               wr_cmpb_l;
   logic               wr_high;

   // bit 0 is the capture pin, bit 1 the external count clock
   frt_sync #(
      .W        (2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin_in   ({ext_count_clock_pin, capture_in_pin}),
      .pin_rise (pin_rise),
      .pin_fall (pin_fall)
   );

   frt_prescale u_prescale (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .sel      (ctl_r.clock_select),
      .ext_rise (pin_rise[1]),
      .inc      (inc)
   );

   assign wr_ctl    = bus_wr && (bus_addr == `FRT_ADDR_CTL);
   assign wr_csr    = bus_wr && (bus_addr == `FRT_ADDR_CSR);
   assign rd_csr    = bus_rd && (bus_addr == `FRT_ADDR_CSR);
   assign wr_cnt_l  = bus_wr && (bus_addr == `FRT_ADDR_CNT_L);
   assign wr_cmpa_l = bus_wr && (bus_addr == `FRT_ADDR_CMPA_L);
   assign wr_cmpb_l = bus_wr && (bus_addr == `FRT_ADDR_CMPB_L);
   assign wr_high   = bus_wr && ((bus_addr == `FRT_ADDR_CNT_H) || (bus_addr == `FRT_ADDR_CMPA_H)
                                 || (bus_addr == `FRT_ADDR_CMPB_H));

   // match is judged on the count pulse while the counter sits on the compare value;
   // a compare register write in the same cycle wins and hides the match
   assign match_a = inc && (cnt_r == cmpa_r) && !wr_cmpa_l;
   assign match_b = inc && (cnt_r == cmpb_r) && !wr_cmpb_l;
   assign cnt_clr = match_a && csr_r.clear_on_compare_a;
   assign cap_evt = csr_r.capture_edge_select ? pin_rise[0] : pin_fall[0];

   always_comb
   begin
      evt.capture   = cap_evt;
      evt.compare_b = match_b;
      evt.compare_a = match_a;
      evt.overflow  = inc && (cnt_r == `FRT_CNT_MAX) && !cnt_clr && !wr_cnt_l;

      // counter: clear beats a low-byte write, which beats the count pulse
      cnt_nxt = cnt_r;
      if (inc)
         cnt_nxt = cnt_r + 16'h0001;
      if (wr_cnt_l)
         cnt_nxt = {temp_r, bus_wdata};
      if (cnt_clr)
         cnt_nxt = `FRT_RST_CNT;

      cmpa_nxt = wr_cmpa_l ? {temp_r, bus_wdata} : cmpa_r;
      cmpb_nxt = wr_cmpb_l ? {temp_r, bus_wdata} : cmpb_r;
      capv_nxt = cap_evt ? cnt_r : capv_r;

      // shared byte latch keeps 16-bit values coherent over the 8-bit bus
      temp_nxt = temp_r;
      if (wr_high)
         temp_nxt = bus_wdata;
      else if (bus_rd && (bus_addr == `FRT_ADDR_CNT_H))
         temp_nxt = cnt_r[7:0];
      else if (bus_rd && (bus_addr == `FRT_ADDR_CAPV_H))
         temp_nxt = capv_r[7:0];

      ctl_nxt = wr_ctl ? frt_pkg::frt_ctl_s'(bus_wdata) : ctl_r;

      // a flag clears only where it was seen as 1 and is now written 0
      flag_clr = (wr_csr ? ~bus_wdata[`FRT_FLAG_HI:`FRT_FLAG_LO] : 4'h0) & arm_r;
      csr_nxt = csr_r;
      csr_nxt[`FRT_FLAG_HI:`FRT_FLAG_LO] = (csr_r[`FRT_FLAG_HI:`FRT_FLAG_LO] & ~flag_clr)
                                           | evt;
      if (wr_csr)
         csr_nxt[3:0] = bus_wdata[3:0];
      // an event in the clearing cycle leaves the flag set and needs a fresh read
      arm_nxt = (arm_r | (rd_csr ? csr_r[`FRT_FLAG_HI:`FRT_FLAG_LO] : 4'h0))
                & ~flag_clr & csr_nxt[`FRT_FLAG_HI:`FRT_FLAG_LO];

      pin_a_nxt = (match_a && ctl_r.compare_a_pin_enable) ? csr_r.compare_a_level : pin_a_r;
      pin_b_nxt = (match_b && ctl_r.compare_b_pin_enable) ? csr_r.compare_b_level : pin_b_r;

      unique case (bus_addr)
         `FRT_ADDR_CTL:    rdata_nxt = ctl_r;
         `FRT_ADDR_CSR:    rdata_nxt = csr_r;
         `FRT_ADDR_CNT_H:  rdata_nxt = cnt_r[15:8];
         `FRT_ADDR_CNT_L:  rdata_nxt = temp_r;
         `FRT_ADDR_CMPA_H: rdata_nxt = cmpa_r[15:8];
         `FRT_ADDR_CMPA_L: rdata_nxt = cmpa_r[7:0];
         `FRT_ADDR_CMPB_H: rdata_nxt = cmpb_r[15:8];
         `FRT_ADDR_CMPB_L: rdata_nxt = cmpb_r[7:0];
         `FRT_ADDR_CAPV_H: rdata_nxt = capv_r[15:8];
         `FRT_ADDR_CAPV_L: rdata_nxt = temp_r;
         default:          rdata_nxt = `FRT_UNMAPPED;
      endcase
      if (!bus_rd)
         rdata_nxt = rdata_r;
   end

   // standby is handled like reset so every register of this module returns to its initial value; the synchroniser and prescaler see only rst
   always_ff @(posedge clk_sys)
   begin
      if (rst || standby)
      begin
         ctl_r   <= `FRT_RST_CTL;
         csr_r   <= `FRT_RST_CSR;
         arm_r   <= 4'h0;
         cnt_r   <= `FRT_RST_CNT;
         cmpa_r  <= `FRT_RST_CMP;
         cmpb_r  <= `FRT_RST_CMP;
         capv_r  <= `FRT_RST_CAPV;
         temp_r  <= 8'h00;
         rdata_r <= 8'h00;
         pin_a_r <= 1'b0;
         pin_b_r <= 1'b0;
      end
      else
      begin
         ctl_r   <= ctl_nxt;
         csr_r   <= csr_nxt;
         arm_r   <= arm_nxt;
         cnt_r   <= cnt_nxt;
         cmpa_r  <= cmpa_nxt;
         cmpb_r  <= cmpb_nxt;
         capv_r  <= capv_nxt;
         temp_r  <= temp_nxt;
         rdata_r <= rdata_nxt;
         pin_a_r <= pin_a_nxt;
         pin_b_r <= pin_b_nxt;
      end
   end

   assign bus_rdata         = rdata_r;
   assign compare_a_out_pin = pin_a_r;
   assign compare_b_out_pin = pin_b_r;
   assign compare_a_out_oe  = ctl_r.compare_a_pin_enable;
   assign compare_b_out_oe  = ctl_r.compare_b_pin_enable;
   // separate level requests; the interrupt controller applies the priority
   assign capture_irq   = csr_r.capture_flag   & ctl_r.capture_irq_enable;
   assign compare_a_irq = csr_r.compare_a_flag & ctl_r.compare_a_irq_enable;
   assign compare_b_irq = csr_r.compare_b_flag & ctl_r.compare_b_irq_enable;
   assign overflow_irq  = csr_r.overflow_flag  & ctl_r.overflow_irq_enable;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || standby);

   property p_ctl_write;
      wr_ctl |=> (ctl_r == $past(bus_wdata));
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control write not stored");

   property p_standby_clear;
      @(posedge clk_sys) disable iff (rst) standby |=> (ctl_r == 8'h00) && (csr_r == 8'h00);
   endproperty
   a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear");

   property p_cap_irq;
      (cap_evt && ctl_r.capture_irq_enable && !wr_ctl |=> capture_irq)
      and (!ctl_r.capture_irq_enable |-> !capture_irq);
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("capture request wrong");

   property p_irq_gate;
      (!ctl_r.compare_a_irq_enable |-> !compare_a_irq) and (!ctl_r.compare_b_irq_enable |-> !compare_b_irq);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("compare request not gated");

   property p_ovf_irq;
      $rose(csr_r.overflow_flag) && ctl_r.overflow_irq_enable |-> overflow_irq;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

   property p_pin_b;
      match_b && ctl_r.compare_b_pin_enable |=> compare_b_out_pin == $past(csr_r.compare_b_level);
   endproperty
   a_pin_b: assert property (p_pin_b) else $error("compare-B pin level wrong");

   property p_pin_a_hold;
      !(match_a && ctl_r.compare_a_pin_enable) ##1 !standby |-> $stable(compare_a_out_pin);
   endproperty
   a_pin_a_hold: assert property (p_pin_a_hold) else $error("compare-A pin moved without match");

   property p_ext_only;
      ctl_r.clock_select == frt_pkg::FRT_CLK_EXT && $stable(ctl_r.clock_select) && !pin_rise[1] |-> !inc;
   endproperty
   a_ext_only: assert property (p_ext_only) else $error("external count without edge");

   property p_flag_keep;
      csr_r.capture_flag && !arm_r[3] && wr_csr |=> csr_r.capture_flag;
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag cleared without read");

   property p_capture;
      cap_evt |=> (capv_r == $past(cnt_r)) && csr_r.capture_flag;
   endproperty
   a_capture: assert property (p_capture) else $error("capture not taken");

   property p_wrap;
      evt.overflow |=> (cnt_r == 16'h0000) && csr_r.overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap not flagged");

   property p_clear_a;
      cnt_clr |=> (cnt_r == 16'h0000) && csr_r.compare_a_flag;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("compare-A clear failed");

   property p_count;
      inc && !cnt_clr && !wr_cnt_l ##1 !standby |-> cnt_r == 16'($past(cnt_r) + 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("counter did not advance");

   c_capture_irq: cover property ($rose(capture_irq));
   c_overflow:    cover property (evt.overflow);
   c_clear_a:     cover property (cnt_clr);
   c_flag_clear:  cover property (|flag_clr);
endmodule
`default_nettype wire

/* File: frt_defines.svh */
// offsets, field positions, reset values and divider taps for the free-running timer
`ifndef FRT_DEFINES_SVH
`define FRT_DEFINES_SVH

// byte addresses on the 8-bit cpu register bus
`define FRT_ADDR_CTL    16'hFFA0
`define FRT_ADDR_CSR    16'hFFA1
`define FRT_ADDR_CNT_H  16'hFFA2
`define FRT_ADDR_CNT_L  16'hFFA3
`define FRT_ADDR_CMPA_H 16'hFFA4
`define FRT_ADDR_CMPA_L 16'hFFA5
`define FRT_ADDR_CMPB_H 16'hFFA6
`define FRT_ADDR_CMPB_L 16'hFFA7
`define FRT_ADDR_CAPV_H 16'hFFA8
`define FRT_ADDR_CAPV_L 16'hFFA9

// reset values
`define FRT_RST_CTL     8'h00
`define FRT_RST_CSR     8'h00
`define FRT_RST_CNT     16'h0000
`define FRT_RST_CMP     16'hFFFF
`define FRT_RST_CAPV    16'h0000
`define FRT_CNT_MAX     16'hFFFF
`define FRT_UNMAPPED    8'h00

// flag field of the control/status register, bits 7 to 4
`define FRT_FLAG_HI     7
`define FRT_FLAG_LO     4

// divider width and the tap bit whose falling edge gives /2, /8, /32
`define FRT_DIV_W       5
`define FRT_TAP_DIV2    0
`define FRT_TAP_DIV8    2
`define FRT_TAP_DIV32   4

`endif

/* File: frt_pkg.sv */
// types shared by the free-running timer control and status logic
package frt_pkg;

   typedef enum logic [1:0] {
      FRT_CLK_DIV2  = 2'b00,
      FRT_CLK_DIV8  = 2'b01,
      FRT_CLK_DIV32 = 2'b10,
      FRT_CLK_EXT   = 2'b11
   } frt_clk_sel_e;

   typedef struct packed {
      logic         capture_irq_enable;
      logic         compare_b_irq_enable;
      logic         compare_a_irq_enable;
      logic         overflow_irq_enable;
      logic         compare_b_pin_enable;
      logic         compare_a_pin_enable;
      frt_clk_sel_e clock_select;
   } frt_ctl_s;

   typedef struct packed {
      logic capture_flag;
      logic compare_b_flag;
      logic compare_a_flag;
      logic overflow_flag;
      logic compare_b_level;
      logic compare_a_level;
      logic capture_edge_select;
      logic clear_on_compare_a;
   } frt_csr_s;

   // one bit per event, in flag order
   typedef struct packed {
      logic capture;
      logic compare_b;
      logic compare_a;
      logic overflow;
   } frt_evt_s;

endpackage

/* File: frt_sync.sv */
// two-flop synchronisers with rise and fall detection for the timer input pins
`timescale 1ns/1ps
`default_nettype none
module frt_sync #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // asynchronous pins
   input  wire logic [W-1:0] pin_in,
   // synchronised edges
   output logic      [W-1:0] pin_rise,
   output logic      [W-1:0] pin_fall
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_nxt;
   logic [W-1:0] s3_nxt;

   always_comb
   begin
      s1_nxt = pin_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   // edges look only at the second and third flops
   assign pin_rise = s2_r & ~s3_r;
   assign pin_fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

/* File: frt_prescale.sv */
// counter clock selection: three divided internal clocks or the external edge
`timescale 1ns/1ps
`include "frt_defines.svh"
`default_nettype none
module frt_prescale (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // selection and external edge
   input  wire frt_pkg::frt_clk_sel_e sel,
   input  wire logic                 ext_rise,
   // one-cycle count enable
   output logic                      inc
);
   logic [`FRT_DIV_W-1:0] div_r;
   logic [`FRT_DIV_W-1:0] div_nxt;
   logic                  src_r;
   logic                  src_nxt;

   always_comb
   begin
      div_nxt = div_r + `FRT_DIV_W'(1);
      unique case (sel)
         frt_pkg::FRT_CLK_DIV2:  src_nxt = div_r[`FRT_TAP_DIV2];
         frt_pkg::FRT_CLK_DIV8:  src_nxt = div_r[`FRT_TAP_DIV8];
         frt_pkg::FRT_CLK_DIV32: src_nxt = div_r[`FRT_TAP_DIV32];
         frt_pkg::FRT_CLK_EXT:   src_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         div_r <= '0;
         src_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         src_r <= src_nxt;
      end
   end

   // falling edge of the chosen tap; a source switch from high to low counts once too
   assign inc = (src_r & ~src_nxt) | ((sel == frt_pkg::FRT_CLK_EXT) & ext_rise);
endmodule
`default_nettype wire

/* File: frt_intc_model.sv */
// interrupt controller model: picks the highest-priority pending request
`timescale 1ns/1ps
`default_nettype none
module frt_intc_model (
   // request lines from the timer
   input  wire logic       capture_irq,
   input  wire logic       compare_a_irq,
   input  wire logic       compare_b_irq,
   input  wire logic       overflow_irq,
   // granted source: 0 none, 1 capture, 2 compare a, 3 compare b, 4 overflow
   output logic      [2:0] vec
);
   always_comb
   begin
      if (capture_irq === 1'b1) vec = 3'h1;
      else if (compare_a_irq === 1'b1) vec = 3'h2;
      else if (compare_b_irq === 1'b1) vec = 3'h3;
      else if (overflow_irq === 1'b1) vec = 3'h4;
      else vec = 3'h0;
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the timer control and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        standby = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic        bus_rd = 1'b0;
   logic        bus_wr = 1'b0;
   logic [7:0]  bus_wdata = 8'h00;
   logic [7:0]  bus_rdata;
   logic        capture_in_pin = 1'b0;
   logic        ext_count_clock_pin = 1'b0;
   logic        pin_a, oe_a, pin_b, oe_b;
   logic        irq_c, irq_a, irq_b, irq_o;
   logic [2:0]  vec;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   logic        rd_q = 1'b0;
   logic [31:0] lfsr = 32'h65F8;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc_cnt = 0;

   always #4 clk_sys = ~clk_sys;

   frt_ctrl u_frt_ctrl (.clk_sys(clk_sys), .rst(rst), .standby(standby), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .capture_in_pin(capture_in_pin), .ext_count_clock_pin(ext_count_clock_pin),
      .compare_a_out_pin(pin_a), .compare_a_out_oe(oe_a), .compare_b_out_pin(pin_b),
      .compare_b_out_oe(oe_b), .capture_irq(irq_c), .compare_a_irq(irq_a),
      .compare_b_irq(irq_b), .overflow_irq(irq_o));

   frt_intc_model u_frt_intc_model (.capture_irq(irq_c), .compare_a_irq(irq_a),
      .compare_b_irq(irq_b), .overflow_irq(irq_o), .vec(vec));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic test_done();
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      bus_wr = 1'b1;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clk_sys);
      bus_wr = 1'b0;
   endtask

   // expected value and mask go into the queue; the monitor compares
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clk_sys);
      bus_rd = 1'b1;
      bus_addr = a;
      exp_q.push_back({m, e});
      @(negedge clk_sys);
      bus_rd = 1'b0;
   endtask

   always @(posedge clk_sys)
   begin
      rd_q <= bus_rd;
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   // read data is settled by the falling edge after the taking edge
   always @(negedge clk_sys)
   begin
      if (rd_q)
      begin
         note = exp_q.pop_front();
         `CHK(bus_rdata & note[15:8], note[7:0])
      end
   end

   initial
   begin
      cyc(20);
      rst = 1'b0;
      `CHK({pin_a, pin_b, oe_a, oe_b, vec}, 7'h00)
      rd(16'hFFA0, 8'h00, 8'hFF);
      rd(16'hFFA1, 8'h00, 8'hFF);
      rd(16'hFFB0, 8'h00, 8'hFF);
      for (int i = 0; i < 4; i++)
      begin
         lfsr = lfsr_next(lfsr);
         wr(16'hFFA0, lfsr[7:0]);
         rd(16'hFFA0, lfsr[7:0], 8'hFF);
      end
      standby = 1'b1;
      cyc(2);
      standby = 1'b0;
      rd(16'hFFA0, 8'h00, 8'hFF);
      // compare a clears the counter at 0x40, both pins go high
      wr(16'hFFA4, 8'h00);
      wr(16'hFFA5, 8'h40);
      wr(16'hFFA6, 8'h00);
      wr(16'hFFA7, 8'h20);
      wr(16'hFFA1, 8'h0D);
      wr(16'hFFA0, 8'h0C);
      wr(16'hFFA2, 8'h00);
      wr(16'hFFA3, 8'h00);
      // long enough that a counter without the clear would pass 0x00FF
      cyc(600);
      rd(16'hFFA1, 8'h6D, 8'hFF);
      rd(16'hFFA2, 8'h00, 8'hFF);
      `CHK({pin_a, pin_b, oe_a, oe_b}, 4'hF)
      // ones into the flags leave them alone; capture on rising edge
      wr(16'hFFA1, 8'hEF);
      capture_in_pin = 1'b1;
      cyc(8);
      rd(16'hFFA1, 8'hEF, 8'hFF);
      for (int i = 0; i < 4; i++)
      begin
         wr(16'hFFA0, (8'h80 >> i) | 8'h0C);
         cyc(2);
         `CHK(vec, (i == 0) ? 3'h1 : (i == 1) ? 3'h3 : (i == 2) ? 3'h2 : 3'h0)
      end
      // overflow from 0xFFF0
      wr(16'hFFA0, 8'h10);
      wr(16'hFFA2, 8'hFF);
      wr(16'hFFA3, 8'hF0);
      wr(16'hFFA1, 8'h0E);
      cyc(60);
      `CHK({vec, irq_o}, 4'h9)
      wr(16'hFFA1, 8'h0E);
      rd(16'hFFA1, 8'h1E, 8'h1F);
      wr(16'hFFA1, 8'h0E);
      cyc(1);
      rd(16'hFFA1, 8'h0E, 8'h1F);
      `CHK(irq_o, 1'b0)
      // capture on the falling edge
      wr(16'hFFA1, 8'h0C);
      capture_in_pin = 1'b0;
      cyc(8);
      rd(16'hFFA1, 8'h8C, 8'h8F);
      // external clock: five rising edges
      wr(16'hFFA0, 8'h03);
      wr(16'hFFA2, 8'h00);
      wr(16'hFFA3, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         ext_count_clock_pin = 1'b1;
         cyc(4);
         ext_count_clock_pin = 1'b0;
         cyc(4);
      end
      rd(16'hFFA2, 8'h00, 8'hFF);
      rd(16'hFFA3, 8'h05, 8'hFF);
      // 64 system clock cycles per internal rate: 32, 8 and 2 counts
      for (int i = 0; i < 3; i++)
      begin
         wr(16'hFFA0, 8'(i));
         wr(16'hFFA2, 8'h00);
         wr(16'hFFA3, 8'h00);
         cyc(63);
         rd(16'hFFA2, 8'h00, 8'hFF);
         rd(16'hFFA3, 8'h20 >> (2 * i), 8'hFF);
      end
      cyc(3);
      test_done();
   end
endmodule
`default_nettype wire
